// [dv/sdram_mode_regs_burst_order_tb.sv]
/*
 * sdram_mode_regs_burst_order_tb: directed test of the mode register
 * bank, burst column order and precharge timer.
 * assumes: smrb_pkg compiled first; controller model drives inputs.
 */
`timescale 1ns/1ps
module sdram_mode_regs_burst_order_tb;
  logic sys_clk_i;
  logic rst_n_i;
  smrb_pkg::smrb_cmd_t cmd;
  logic rd_valid, dqs, bstart, bvalid, ap_end, pre, init;
  logic [7:0] rd_data;
  logic [9:0] bcol, col;
  smrb_pkg::smrb_cfg_t cfg;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] ops [5] = '{8'h22, 8'h2B, 8'h24, 8'h32, 8'h23};
  logic [9:0] cols [5] = '{10'h007, 10'h00A, 10'h01E, 10'h00E, 10'h01C};

  // ------------------------------------------------------------
  // clock, reset and instances
  // ------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  smrb_ctrl_model ctl (.sys_clk_i(sys_clk_i), .auto_init_i(init),
    .cmd_o(cmd), .burst_start_o(bstart), .burst_col_o(bcol),
    .wr_ap_end_o(ap_end));
  smrb_mode_regs uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cmd_i(cmd), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .dqs_toggle_o(dqs), .burst_start_i(bstart), .burst_col_i(bcol),
    .beat_valid_o(bvalid), .beat_col_o(col), .wr_ap_end_i(ap_end),
    .precharge_start_o(pre), .auto_init_status_o(init), .cfg_o(cfg));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check

  // read answer one cycle after the strobe, pulse one cycle wide
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    ctl.issue(1'b0, a, 8'h00);
    check(rd_valid === 1'b1 && dqs === 1'b1 && rd_data === exp,
      "read");
    @(posedge sys_clk_i);
    #1;
    check(rd_valid === 1'b0 && dqs === 1'b0, "read pulse");
  endtask : rd

  // setup written, then every field compared at its bit position
  task automatic wr_setup(input logic [7:0] op);
    ctl.issue(1'b1, 8'h01, op);
    check(cfg.burst_length_field === op[2:0] &&
      cfg.burst_ordering_type === op[3] && cfg.wrap_control === op[4] &&
      cfg.write_recovery_cycles === op[7:5], "setup fields");
  endtask : wr_setup

  // expected column of beat i, from the burst ordering table
  function automatic logic [9:0] exp_col(input logic [7:0] op,
      input logic [9:0] c, input int i);
    logic [9:0] s, m, x;
    s = {c[9:1], 1'b0};
    m = (op[2:0] == 3'h3) ? 10'h007 : (op[2:0] == 3'h4) ? 10'h00F : 10'h003;
    if (op[4]) return s + i[9:0];
    x = op[3] ? (s ^ i[9:0]) : (s + i[9:0]);
    return (s & ~m) | (x & m);
  endfunction : exp_col

  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // hang guard: the whole run needs well under 2000 cycles
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    check(cfg === {3'h2, 1'b0, 1'b0, 3'h1} && init === 1'b1, "reset");
    rd(8'h00, 8'h01);
    rd(8'h01, smrb_pkg::UNDEFINED_READ_DATA);
    rd(8'h0B, smrb_pkg::UNDEFINED_READ_DATA);
    ctl.wait_init(1000, n);
    check(init === 1'b0 && n >= 390 && n <= 400, "init time");
    rd(8'h00, 8'h00);
    wr_setup(8'h4B);
    ctl.issue(1'b1, 8'h00, 8'hFF);
    check(cfg === {3'h3, 1'b1, 1'b0, 3'h2}, "ro write");
    rd(8'h00, 8'h00);
    // five burst setups (no bl16 interleave) walked beat by beat, then the gap after it
    for (int k = 0; k < 5; k++) begin
      wr_setup(ops[k]);
      ctl.burst(cols[k]);
      n = (ops[k][2:0] == 3'h2) ? 4 : (ops[k][2:0] == 3'h3) ? 8 : 16;
      for (int i = 0; i < n; i++) begin
        check(bvalid === 1'b1 && col === exp_col(ops[k], cols[k], i),
          "beat");
        @(posedge sys_clk_i);
        #1;
      end
      check(bvalid === 1'b0, "burst length");
    end
    // every legal recovery code, delay counted from the taking edge
    for (int c = 1; c <= 6; c++) begin
      wr_setup({c[2:0], 5'h02});
      ctl.ap_end();
      n = 0;
      while (pre !== 1'b1 && n < 20) begin
        @(posedge sys_clk_i);
        #1;
        n++;
      end
      // pulse shows after edge n, so it is sampled high at edge n + 1
      check(n + 1 == c + 2, "recovery cycles");
      @(posedge sys_clk_i);
      #1;
      check(pre === 1'b0, "precharge pulse");
    end
    tally_and_finish();
  end
endmodule : sdram_mode_regs_burst_order_tb

// [dv/smrb_ctrl_model.sv]
/*
 * smrb_ctrl_model: memory controller on the command side of the bank.
 * assumes: the bank samples every input on the rising edge of sys_clk_i.
 */
`timescale 1ns/1ps
module smrb_ctrl_model (
  // clock and status
  input wire logic sys_clk_i,
  input wire logic auto_init_i,
  // command side
  output smrb_pkg::smrb_cmd_t cmd_o,
  output logic burst_start_o,
  output logic [smrb_pkg::COL_W-1:0] burst_col_o,
  output logic wr_ap_end_o
);
  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  initial begin
    cmd_o = '0;
    burst_start_o = 1'b0;
    burst_col_o = '0;
    wr_ap_end_o = 1'b0;
  end

  // ------------------------------------------------------------
  // command tasks
  // ------------------------------------------------------------
  // only mrr/mrw; one caller writes 8'hFF to the read-only info address
  task automatic issue(input logic wr, input logic [7:0] a,
                       input logic [7:0] op);
    @(posedge sys_clk_i);
    #1;
    cmd_o.mode_register_read_cmd = !wr;
    cmd_o.mode_register_write_cmd = wr;
    cmd_o.addr = a;
    cmd_o.op = op;
    @(posedge sys_clk_i);
    #1;
    cmd_o.mode_register_read_cmd = 1'b0;
    cmd_o.mode_register_write_cmd = 1'b0;
    // inverted leftovers expose a decoder that ignores the strobe
    cmd_o.addr = ~a;
    cmd_o.op = ~op;
  endtask : issue

  // callers avoid bl16 interleave and page-crossing no-wrap
  task automatic burst(input logic [smrb_pkg::COL_W-1:0] c);
    @(posedge sys_clk_i);
    #1;
    burst_start_o = 1'b1;
    burst_col_o = c;
    @(posedge sys_clk_i);
    #1;
    burst_start_o = 1'b0;
    burst_col_o = ~c;
  endtask : burst

  // one pulse marks the end of an auto-precharge write
  task automatic ap_end();
    @(posedge sys_clk_i);
    #1;
    wr_ap_end_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    wr_ap_end_o = 1'b0;
  endtask : ap_end

  // no ordinary traffic before auto-init reports done
  task automatic wait_init(input int lim, output int n);
    n = 0;
    while (auto_init_i !== 1'b0 && n < lim) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask : wait_init
endmodule : smrb_ctrl_model

// [hw/smrb_burst_addr.sv]
/*
 * smrb_burst_addr: combinational column for one beat of a burst.
 * assumes: start column already has bit zero cleared; len is 4, 8 or 16.
 */
`timescale 1ns/1ps
module smrb_burst_addr (
  // burst setup
  input wire logic [smrb_pkg::COL_W-1:0] start_i,
  input wire logic [3:0] beat_i,
  input wire logic [4:0] len_i,
  input wire logic interleave_i,
  input wire logic no_wrap_i,
  // resulting column
  output logic [smrb_pkg::COL_W-1:0] col_o
);

  // ------------------------------------------------------------------
  // offset arithmetic
  // ------------------------------------------------------------------
  // offset width by length
  wire [3:0] mask = 4'(len_i - 5'h01);
  wire [3:0] seq_low = 4'(start_i[3:0] + beat_i) & mask;
  wire [3:0] int_low = (start_i[3:0] ^ beat_i) & mask;
  wire [3:0] low = interleave_i ? int_low : seq_low;
  wire [smrb_pkg::COL_W-1:0] wrap_col =
    {start_i[smrb_pkg::COL_W-1:4], (start_i[3:0] & ~mask) | low};
  wire [smrb_pkg::COL_W-1:0] nowrap_col =
    start_i + {{(smrb_pkg::COL_W-4){1'b0}}, beat_i};

  assign col_o = no_wrap_i ? nowrap_col : wrap_col;

endmodule : smrb_burst_addr

// [hw/smrb_mode_regs.sv]
/*
 * smrb_mode_regs: mode register bank with burst column sequencer and
 * write-recovery precharge timer.
 * assumes: command strobes come from same-clock decode logic, one
 * cycle each; the controller keeps its own obligations.
 */
`timescale 1ns/1ps
module smrb_mode_regs (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // mode register commands
  input wire smrb_pkg::smrb_cmd_t cmd_i,
  // read answer
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic dqs_toggle_o,
  // burst start
  input wire logic burst_start_i,
  input wire logic [smrb_pkg::COL_W-1:0] burst_col_i,
  // burst beats
  output logic beat_valid_o,
  output logic [smrb_pkg::COL_W-1:0] beat_col_o,
  // auto-precharge
  input wire logic wr_ap_end_i,
  output logic precharge_start_o,
  // status and setup
  output logic auto_init_status_o,
  output smrb_pkg::smrb_cfg_t cfg_o
);

  // ------------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------------
  smrb_pkg::smrb_cfg_t cfg_q;        // feature setup
  logic [smrb_pkg::INIT_CNT_W-1:0] init_cnt_q;  // auto-init countdown
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic [smrb_pkg::COL_W-1:0] start_q;  // latched burst start
  logic [4:0] beat_q; // next beat index, five bits so sixteen fits
  logic active_q;                       // burst in progress
  logic beat_valid_q;
  logic [smrb_pkg::COL_W-1:0] beat_col_q;
  logic [3:0] wr_cnt_q;                 // recovery countdown

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  // both addresses decoded
  wire hit_info = cmd_i.addr == smrb_pkg::ADDR_DEVICE_INFORMATION;
  wire hit_setup = cmd_i.addr == smrb_pkg::ADDR_BURST_AND_WR_SETUP;
  // only the setup address is writable
  wire setup_wr = cmd_i.mode_register_write_cmd && hit_setup;
  wire init_busy = init_cnt_q != '0;
  // reserved bits of info forced zero
  wire [7:0] info_word = {6'h00, smrb_pkg::DEVICE_TYPE_SDRAM, init_busy};
  wire [7:0] rd_word = hit_info ? info_word : smrb_pkg::UNDEFINED_READ_DATA;

  // ------------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------------
  // burst length decode
  wire [4:0] burst_len =
    (cfg_q.burst_length_field == smrb_pkg::BL_CODE_16) ? smrb_pkg::LEN_16 :
    (cfg_q.burst_length_field == smrb_pkg::BL_CODE_8) ? smrb_pkg::LEN_8 :
    smrb_pkg::LEN_4;
  wire [3:0] nwr_cycles =
    {1'b0, cfg_q.write_recovery_cycles} + smrb_pkg::NWR_CODE_OFFSET;
  wire [smrb_pkg::COL_W-1:0] start_even = {burst_col_i[smrb_pkg::COL_W-1:1],
    1'b0};
  wire [smrb_pkg::COL_W-1:0] addr_start = burst_start_i ? start_even : start_q;
  wire [3:0] addr_beat = burst_start_i ? 4'h0 : beat_q[3:0];
  wire [smrb_pkg::COL_W-1:0] next_col;
  // a four-bit index would wrap to zero after beat 15 and never end
  wire more_beats = active_q && (beat_q < burst_len);

  smrb_burst_addr u_addr (
    .start_i(addr_start),
    .beat_i(addr_beat),
    .len_i(burst_len),
    .interleave_i(cfg_q.burst_ordering_type == smrb_pkg::BT_INTERLEAVED),
    .no_wrap_i(cfg_q.wrap_control == smrb_pkg::WC_NO_WRAP),
    .col_o(next_col)
  );

  // ------------------------------------------------------------------
  // setup register
  // ------------------------------------------------------------------
  // only whole-byte writes to the setup address land here
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= '{smrb_pkg::BL_CODE_4, smrb_pkg::BT_SEQUENTIAL,
                 smrb_pkg::WC_WRAP, smrb_pkg::NWR_CODE_RESET};
    end else if (setup_wr) begin
      cfg_q <= '{cmd_i.op[smrb_pkg::BL_LSB +: 3], cmd_i.op[smrb_pkg::BT_POS],
                 cmd_i.op[smrb_pkg::WC_POS], cmd_i.op[smrb_pkg::NWR_LSB +: 3]};
    end
  end

  // ------------------------------------------------------------------
  // auto-init and read answer
  // ------------------------------------------------------------------
  // countdown while init runs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_cnt_q <= smrb_pkg::INIT_CNT_W'(smrb_pkg::INIT_CYCLES);
    end else if (init_busy) begin
      init_cnt_q <= init_cnt_q - 1'b1;
    end
  end

  // read data registered one cycle after the command
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      rd_valid_q <= cmd_i.mode_register_read_cmd;
      if (cmd_i.mode_register_read_cmd) begin
        rd_data_q <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------------
  // burst sequencer
  // ------------------------------------------------------------------
  // a new start restarts the burst even mid-flight
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= '0;
      beat_q <= 5'h00;
      active_q <= 1'b0;
      beat_valid_q <= 1'b0;
      beat_col_q <= '0;
    end else if (burst_start_i || more_beats) begin
      if (burst_start_i) begin
        start_q <= start_even;
      end
      beat_q <= burst_start_i ? 5'h01 : 5'(beat_q + 5'h01);
      active_q <= 1'b1;
      beat_valid_q <= 1'b1;
      beat_col_q <= next_col;
    end else begin
      active_q <= 1'b0;
      beat_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // write recovery timer
  // ------------------------------------------------------------------
  // load recovery count on burst end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_cnt_q <= 4'h0;
    end else if (wr_ap_end_i) begin
      wr_cnt_q <= nwr_cycles;
    end else if (wr_cnt_q != 4'h0) begin
      wr_cnt_q <= wr_cnt_q - 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rd_data_q;
  assign dqs_toggle_o = rd_valid_q;
  assign beat_valid_o = beat_valid_q;
  assign beat_col_o = beat_col_q;
  assign precharge_start_o = wr_cnt_q == 4'h1;
  assign auto_init_status_o = init_busy;
  assign cfg_o = cfg_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_read_answer: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_i.mode_register_read_cmd |=> rd_valid_o && dqs_toggle_o)
    else $error("read command not answered next cycle");
  chk_info_reserved: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_i.mode_register_read_cmd && hit_info |=> rd_data_o[7:2] == 6'h00)
    else $error("reserved info bits not zero");
  chk_info_type: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_i.mode_register_read_cmd && hit_info |=> rd_data_o[1] == 1'b0)
    else $error("device type bit not zero");
  chk_init_bit: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_i.mode_register_read_cmd && hit_info |=> rd_data_o[0] == $past(auto_init_status_o))
    else $error("auto-init bit wrong");
  chk_ro_write: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_i.mode_register_write_cmd && !hit_setup |=> $stable(cfg_o))
    else $error("write to other address changed setup");
  chk_setup_store: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_wr |=> cfg_o.write_recovery_cycles == $past(cmd_i.op[7:5]))
    else $error("recovery field not stored");
  chk_col_even: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    beat_valid_o && beat_q[0] |-> beat_col_o[0] == 1'b0)
    else $error("even beat on odd column");
  chk_first_beat: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    burst_start_i |=> beat_valid_o &&
      beat_col_o == {$past(burst_col_i[smrb_pkg::COL_W-1:1]), 1'b0})
    else $error("first beat column wrong");
  chk_recovery_load: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_ap_end_i |=> wr_cnt_q == {1'b0, $past(cfg_q.write_recovery_cycles)}
      + 4'h2 ##0 !precharge_start_o)
    else $error("recovery count not loaded");
  chk_bl4_end: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    burst_start_i && burst_len == smrb_pkg::LEN_4 && !setup_wr
      ##1 (!burst_start_i && !setup_wr) [*4] |=> !beat_valid_o)
    else $error("four-beat burst overran");

endmodule : smrb_mode_regs

// [hw/smrb_pkg.sv]
/*
 * smrb_pkg: shared constants and types for the mode register bank and
 * burst column sequencer of a low-power ddr sdram.
 * assumes: one 40 mhz clock; the command decoder upstream presents
 * mode register commands and burst events as single-cycle strobes.
 */
package smrb_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;  // 40 mhz
  localparam int INIT_TIME_NS = 10000;   // internal auto-init run time
  // longest-type wait rounds down, never below one cycle
  localparam int INIT_CYCLES_RAW = (INIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int INIT_CYCLES = (INIT_CYCLES_RAW < 1) ? 1 : INIT_CYCLES_RAW;
  localparam int INIT_CNT_W = 10;

  // ------------------------------------------------------------------
  // register addresses and field layout
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_DEVICE_INFORMATION = 8'h00;
  localparam logic [7:0] ADDR_BURST_AND_WR_SETUP = 8'h01;
  localparam int DEVICE_TYPE_BIT_POS = 1;
  localparam int AUTO_INIT_STATUS_POS = 0;
  localparam int BL_LSB = 0;
  localparam int BT_POS = 3;
  localparam int WC_POS = 4;
  localparam int NWR_LSB = 5;
  localparam logic DEVICE_TYPE_SDRAM = 1'b0;
  // answer for write-only / reserved reads; value is arbitrary
  localparam logic [7:0] UNDEFINED_READ_DATA = 8'hA5;

  // ------------------------------------------------------------------
  // field codes and reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic BT_SEQUENTIAL = 1'b0;
  localparam logic BT_INTERLEAVED = 1'b1;
  localparam logic WC_WRAP = 1'b0;
  localparam logic WC_NO_WRAP = 1'b1;
  localparam logic [2:0] NWR_CODE_RESET = 3'h1;
  localparam logic [3:0] NWR_CODE_OFFSET = 4'h2;  // code 1 -> 3 cycles

  localparam int COL_W = 10;  // column address width
  localparam logic [4:0] LEN_4 = 5'h04;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic mode_register_read_cmd;        // mode_register_read_cmd strobe
    logic mode_register_write_cmd;        // mode_register_write_cmd strobe
    logic [7:0] addr; // mode register address
    logic [7:0] op;   // write operand
  } smrb_cmd_t;

  typedef struct packed {
    logic [2:0] burst_length_field;
    logic burst_ordering_type;
    logic wrap_control;
    logic [2:0] write_recovery_cycles;
  } smrb_cfg_t;

endpackage : smrb_pkg
